// *** verilog/mtf_top.v ***
// transmit control and pause flow control of the ethernet mac, with ahb-lite register slave
`timescale 1ns/1ns
module mtf_top
(
    input  wire        CLK_I,
    input  wire        RESET_I,
    input  wire        CE_I,
    // ahb-lite slave
    input  wire        HSEL_I,
    input  wire [11:0] HADDR_I,
    input  wire [1:0]  HTRANS_I,
    input  wire        HWRITE_I,
    input  wire [2:0]  HSIZE_I,
    input  wire [31:0] HWDATA_I,
    input  wire        HREADY_I,
    output wire [31:0] HRDATA_O,
    output wire        HREADYOUT_O,
    output wire        HRESP_O,
    output wire        IRQ_O,
    // mac status
    input  wire        FULL_DUPLEX_I,
    input  wire [15:0] RX_FIFO_FILL_LEVEL_I,
    input  wire [7:0]  WATERMARK_ON_I,
    input  wire [7:0]  WATERMARK_OFF_I,
    // transmit data path
    input  wire        TX_FRAME_READY_I,
    input  wire        TX_FRAME_DONE_I,
    output wire        TX_FRAME_START_O,
    output wire        TX_CORRUPT_FCS_O,
    // pause frame generator
    output wire        PAUSE_SEND_O,
    output wire [15:0] PAUSE_SEND_TIME_O,
    input  wire        PAUSE_SENT_I,
    // receive pause decode
    input  wire        RX_PAUSE_VALID_I,
    input  wire [15:0] RX_PAUSE_QUANTA_I,
    output wire        RX_PAUSE_DECODE_EN_O,
    output wire        RX_PAUSE_FORWARD_O,
    // back-off
    input  wire        BACKOFF_STEP_I,
    output wire [15:0] BACKOFF_RANDOM_O
);
`include "mtf_consts.vh"
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_BUSY = 2'b01;
    localparam [1:0] ST_OFF  = 2'b10;

    reg        transmitter_on_ff;
    reg        tx_off_done_ff;
    reg        corrupt_checksum_enable_ff;
    reg        manual_pause_send_ff;
    reg        auto_pause_generation_enable_ff;
    reg        pause_honour_enable_ff;
    reg        pass_pause_frames_ff;
    reg [15:0] pause_time_value_ff;
    reg [15:0] backoff_seed_ff;
    reg [2:0]  irq_status_ff;
    reg [2:0]  irq_mask_ff;
    reg [1:0]  tx_state_ff;
    reg [1:0]  nxt_tx_state;
    reg        auto_paused_ff;
    reg        pend_on_ff;
    reg        pend_off_ff;
    reg        send_busy_ff;
    reg [15:0] send_time_ff;
    reg        send_manual_ff;
    reg        seed_load_ff;
    reg        wr_pend_ff;
    reg [11:0] wr_addr_ff;
    reg [31:0] rdata_ff;

    // bus decode: address phase sampled while hready high
    wire        take     = HSEL_I & HTRANS_I[1] & HREADY_I;
    wire        rd_take  = take & ~HWRITE_I;
    wire        wr_now   = wr_pend_ff;
    wire [11:0] rd_addr  = HADDR_I;
    wire        wr_txc   = wr_now & (wr_addr_ff == `MTF_OFS_TX_CTRL);
    wire        wr_flow  = wr_now & (wr_addr_ff == `MTF_OFS_FLOW);
    wire        wr_seed  = wr_now & (wr_addr_ff == `MTF_OFS_SEED);
    wire        wr_mask  = wr_now & (wr_addr_ff == `MTF_OFS_IRQ_MASK);
    wire        rd_stat  = rd_take & (rd_addr == `MTF_OFS_IRQ_STATUS);

    // flow control lives only in full duplex
    wire        fc_ok     = FULL_DUPLEX_I;
    wire [6:0]  fill_blks = RX_FIFO_FILL_LEVEL_I[15:`MTF_FILL_SHIFT];
    wire        over_on   = ({1'b0, fill_blks} >= WATERMARK_ON_I);
    wire        under_off = ({1'b0, fill_blks} <= WATERMARK_OFF_I);
    wire        pause_active;
    wire        rx_pause  = RX_PAUSE_VALID_I & pause_honour_enable_ff & fc_ok;
    wire        txoff_evt = (tx_state_ff != ST_OFF) & (nxt_tx_state == ST_OFF);
    wire        sent_evt  = send_busy_ff & PAUSE_SENT_I;
    // a due pause frame beats a waiting data frame, so the two never start together
    wire        pause_due = ~send_busy_ff & fc_ok & transmitter_on_ff & (manual_pause_send_ff |
                            (auto_pause_generation_enable_ff & (pend_on_ff | pend_off_ff)));

    // transmit state: a started frame always runs to its end
    always @*
    begin
        case (tx_state_ff)
            ST_IDLE:
                if (!transmitter_on_ff)
                    nxt_tx_state = ST_OFF;
                else if (TX_FRAME_READY_I && !pause_active && !send_busy_ff && !pause_due)
                    nxt_tx_state = ST_BUSY;
                else
                    nxt_tx_state = ST_IDLE;
            ST_BUSY:
                if (TX_FRAME_DONE_I)
                    nxt_tx_state = transmitter_on_ff ? ST_IDLE : ST_OFF;
                else
                    nxt_tx_state = ST_BUSY;
            ST_OFF:
                nxt_tx_state = transmitter_on_ff ? ST_IDLE : ST_OFF;
            default:
                nxt_tx_state = ST_OFF;
        endcase
    end

    always @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            tx_state_ff <= ST_OFF;
        else if (CE_I)
            tx_state_ff <= nxt_tx_state;
    end

    // software registers; hardware set of the disabled flag wins over a clear
    always @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            transmitter_on_ff               <= 1'b0;
            tx_off_done_ff                  <= 1'b0;
            corrupt_checksum_enable_ff      <= 1'b0;
            manual_pause_send_ff            <= 1'b0;
            auto_pause_generation_enable_ff <= 1'b0;
            pause_honour_enable_ff          <= 1'b0;
            pass_pause_frames_ff            <= 1'b0;
            pause_time_value_ff             <= `MTF_PAUSE_RESET;
            backoff_seed_ff                 <= `MTF_SEED_RESET;
            irq_mask_ff                     <= 3'h0;
            seed_load_ff                    <= 1'b1;
        end
        else if (CE_I)
        begin
            seed_load_ff <= wr_seed;
            if (wr_txc)
            begin
                transmitter_on_ff          <= HWDATA_I[`MTF_BIT_TX_ON];
                corrupt_checksum_enable_ff <= HWDATA_I[`MTF_BIT_CORRUPT];
            end
            // set only by a completed shutdown; a write of one clears unless a shutdown completes in the same cycle
            if (txoff_evt)
                tx_off_done_ff <= 1'b1;
            else if (wr_txc && HWDATA_I[`MTF_BIT_TX_OFF_DONE])
                tx_off_done_ff <= 1'b0;
            if (wr_flow)
            begin
                auto_pause_generation_enable_ff <= HWDATA_I[`MTF_BIT_AUTO_PAUSE];
                pause_honour_enable_ff          <= HWDATA_I[`MTF_BIT_HONOUR];
                pass_pause_frames_ff            <= HWDATA_I[`MTF_BIT_PASS_PAUSE];
                pause_time_value_ff             <= HWDATA_I[15:0];
            end
            // manual send bit self-clears once its frame went out
            if (wr_flow && HWDATA_I[`MTF_BIT_MANUAL_SEND])
                manual_pause_send_ff <= 1'b1;
            else if (sent_evt && send_manual_ff)
                manual_pause_send_ff <= 1'b0;
            if (wr_seed)
                backoff_seed_ff <= HWDATA_I[15:0];
            if (wr_mask)
                irq_mask_ff <= HWDATA_I[2:0];
        end
    end

    // pause frame scheduler: manual first, then watermark on, then off
    always @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            auto_paused_ff <= 1'b0;
            pend_on_ff     <= 1'b0;
            pend_off_ff    <= 1'b0;
            send_busy_ff   <= 1'b0;
            send_time_ff   <= 16'h0000;
            send_manual_ff <= 1'b0;
        end
        else if (CE_I)
        begin
            if (!auto_pause_generation_enable_ff || !fc_ok)
            begin
                auto_paused_ff <= 1'b0;
                pend_on_ff     <= 1'b0;
                pend_off_ff    <= 1'b0;
            end
            else if (!auto_paused_ff && over_on)
            begin
                auto_paused_ff <= 1'b1;
                pend_on_ff     <= 1'b1;
                pend_off_ff    <= 1'b0;
            end
            else if (auto_paused_ff && under_off)
            begin
                auto_paused_ff <= 1'b0;
                pend_off_ff    <= 1'b1;
                pend_on_ff     <= 1'b0;
            end
            if (send_busy_ff)
            begin
                if (PAUSE_SENT_I)
                    send_busy_ff <= 1'b0;
            end
            else if (fc_ok && tx_state_ff == ST_IDLE && transmitter_on_ff)
            begin
                // a data frame in flight is never cut; the scheduler waits for idle
                if (manual_pause_send_ff)
                begin
                    send_busy_ff   <= 1'b1;
                    send_manual_ff <= 1'b1;
                    send_time_ff   <= pause_time_value_ff;
                end
                else if (pend_on_ff && auto_pause_generation_enable_ff)
                begin
                    send_busy_ff   <= 1'b1;
                    send_manual_ff <= 1'b0;
                    send_time_ff   <= pause_time_value_ff;
                    pend_on_ff     <= 1'b0;
                end
                else if (pend_off_ff && auto_pause_generation_enable_ff)
                begin
                    send_busy_ff   <= 1'b1;
                    send_manual_ff <= 1'b0;
                    send_time_ff   <= 16'h0000;
                    pend_off_ff    <= 1'b0;
                end
            end
        end
    end

    // interrupt status: events set, a read clears, a set in the same cycle wins
    wire [2:0] irq_set = {rx_pause, sent_evt, txoff_evt};
    always @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            irq_status_ff <= 3'h0;
        else if (CE_I)
            irq_status_ff <= (rd_stat ? 3'h0 : irq_status_ff) | irq_set;
    end

    // write data arrives a cycle after its address phase
    always @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 12'h000;
        end
        else if (CE_I)
        begin
            wr_pend_ff <= take & HWRITE_I & (HSIZE_I == 3'b010);
            wr_addr_ff <= HADDR_I;
        end
    end

    // read mux; unmapped reads return zero, response stays okay
    always @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            rdata_ff <= 32'h0000_0000;
        else if (CE_I && rd_take)
        begin
            case (rd_addr)
                `MTF_OFS_TX_CTRL:
                    rdata_ff <= {29'h0000_0000, corrupt_checksum_enable_ff, tx_off_done_ff, transmitter_on_ff};
                `MTF_OFS_FLOW:
                    rdata_ff <= {manual_pause_send_ff, auto_pause_generation_enable_ff, pause_honour_enable_ff,
                                 pass_pause_frames_ff, 12'h000, pause_time_value_ff};
                `MTF_OFS_SEED:
                    rdata_ff <= {16'h0000, backoff_seed_ff};
                `MTF_OFS_THRESH:
                    rdata_ff <= {16'h0000, WATERMARK_ON_I, WATERMARK_OFF_I};
                `MTF_OFS_IRQ_STATUS:
                    rdata_ff <= {29'h0000_0000, irq_status_ff};
                `MTF_OFS_IRQ_MASK:
                    rdata_ff <= {29'h0000_0000, irq_mask_ff};
                default:
                    rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    mtf_pause_timer u_timer
    (
        .CLK_I    (CLK_I),
        .RESET_I  (RESET_I),
        .ce_i     (CE_I),
        .load_i   (rx_pause),
        .quanta_i (RX_PAUSE_QUANTA_I),
        .clear_i  (~pause_honour_enable_ff | ~fc_ok),
        .active_o (pause_active)
    );

    mtf_backoff_lfsr u_lfsr
    (
        .CLK_I    (CLK_I),
        .RESET_I  (RESET_I),
        .ce_i     (CE_I),
        .load_i   (seed_load_ff),
        .seed_i   (backoff_seed_ff),
        .step_i   (BACKOFF_STEP_I),
        .value_o  (BACKOFF_RANDOM_O)
    );

    assign HRDATA_O             = rdata_ff;
    assign HREADYOUT_O          = 1'b1;
    assign HRESP_O              = 1'b0;
    assign IRQ_O                = |(irq_status_ff & irq_mask_ff);
    assign TX_FRAME_START_O     = (tx_state_ff == ST_IDLE) & (nxt_tx_state == ST_BUSY) & CE_I;
    assign TX_CORRUPT_FCS_O     = corrupt_checksum_enable_ff;
    assign PAUSE_SEND_O         = send_busy_ff;
    assign PAUSE_SEND_TIME_O    = send_time_ff;
    assign RX_PAUSE_DECODE_EN_O = pause_honour_enable_ff & fc_ok;
    assign RX_PAUSE_FORWARD_O   = pass_pause_frames_ff;
endmodule

// *** inc/mtf_consts.vh ***
// register offsets, field positions, reset values and timing counts of the transmit flow-control block
`ifndef MTF_CONSTS_VH
`define MTF_CONSTS_VH
`define MTF_OFS_TX_CTRL      12'h0108
`define MTF_OFS_FLOW         12'h010C
`define MTF_OFS_SEED         12'h0110
`define MTF_OFS_THRESH       12'h0114
`define MTF_OFS_IRQ_STATUS   12'h0118
`define MTF_OFS_IRQ_MASK     12'h011C
`define MTF_BIT_TX_ON        0
`define MTF_BIT_TX_OFF_DONE  1
`define MTF_BIT_CORRUPT      2
`define MTF_BIT_PASS_PAUSE   28
`define MTF_BIT_HONOUR       29
`define MTF_BIT_AUTO_PAUSE   30
`define MTF_BIT_MANUAL_SEND  31
`define MTF_SEED_RESET       16'h9876
`define MTF_PAUSE_RESET      16'h0000
`define MTF_SLOT_BITS        512
`define MTF_BIT_TIME_NS      8
`define MTF_CLK_NS           50
`define MTF_SLOT_CYCLES      ((`MTF_SLOT_BITS * `MTF_BIT_TIME_NS + `MTF_CLK_NS - 1) / `MTF_CLK_NS)
`define MTF_FILL_SHIFT       9
`define MTF_IRQ_TXOFF        0
`define MTF_IRQ_PAUSE_SENT   1
`define MTF_IRQ_PAUSE_RCVD   2
`endif

// *** verilog/mtf_pause_timer.v ***
// hold-off timer counting pause quanta times slot time
`timescale 1ns/1ns
module mtf_pause_timer
(
    input  wire        CLK_I,
    input  wire        RESET_I,
    input  wire        ce_i,
    input  wire        load_i,
    input  wire [15:0] quanta_i,
    input  wire        clear_i,
    output wire        active_o
);
`include "mtf_consts.vh"
    localparam integer SLOT_INT = `MTF_SLOT_CYCLES;
    localparam [15:0]  SLOT_CYC = SLOT_INT[15:0];
    reg [15:0] quanta_ff;
    reg [15:0] slot_ff;
    reg [15:0] nxt_quanta;
    reg [15:0] nxt_slot;

    // a new frame reloads, zero ends the hold-off at once
    always @*
    begin
        nxt_quanta = quanta_ff;
        nxt_slot   = slot_ff;
        if (clear_i)
        begin
            nxt_quanta = 16'h0000;
            nxt_slot   = 16'h0000;
        end
        else if (load_i)
        begin
            nxt_quanta = quanta_i;
            nxt_slot   = SLOT_CYC - 16'h0001;
        end
        else if (quanta_ff != 16'h0000)
        begin
            if (slot_ff == 16'h0000)
            begin
                nxt_quanta = quanta_ff - 16'h0001;
                nxt_slot   = SLOT_CYC - 16'h0001;
            end
            else
                nxt_slot = slot_ff - 16'h0001;
        end
    end

    always @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            quanta_ff <= 16'h0000;
            slot_ff   <= 16'h0000;
        end
        else if (ce_i)
        begin
            quanta_ff <= nxt_quanta;
            slot_ff   <= nxt_slot;
        end
    end

    assign active_o = (quanta_ff != 16'h0000);
endmodule

// *** verilog/mtf_backoff_lfsr.v ***
// 16-bit lfsr for collision back-off random values
`timescale 1ns/1ns
module mtf_backoff_lfsr
(
    input  wire        CLK_I,
    input  wire        RESET_I,
    input  wire        ce_i,
    input  wire        load_i,
    input  wire [15:0] seed_i,
    input  wire        step_i,
    output wire [15:0] value_o
);
`include "mtf_consts.vh"
    reg [15:0] lfsr_ff;
    // taps 16,14,13,11 give a maximal sequence
    wire fb = lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10];

    always @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            lfsr_ff <= `MTF_SEED_RESET;
        else if (ce_i)
        begin
            if (load_i)
                lfsr_ff <= (seed_i == 16'h0000) ? `MTF_SEED_RESET : seed_i; // all-zero would lock up
            else if (step_i)
                lfsr_ff <= {lfsr_ff[14:0], fb};
        end
    end

    assign value_o = lfsr_ff;
endmodule

// *** sim/mtf_top_props.sv ***
// concurrent checks on the ports of the transmit flow-control block
`timescale 1ns/1ns
module mtf_top_props
(
    input  wire        CLK_I,
    input  wire        RESET_I,
    input  wire        CE_I,
    input  wire        FULL_DUPLEX_I,
    input  wire        TX_FRAME_READY_I,
    input  wire        TX_FRAME_START_O,
    input  wire        PAUSE_SEND_O,
    input  wire [15:0] PAUSE_SEND_TIME_O,
    input  wire        PAUSE_SENT_I,
    input  wire        RX_PAUSE_VALID_I,
    input  wire [15:0] RX_PAUSE_QUANTA_I,
    input  wire        RX_PAUSE_DECODE_EN_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    property p_start_gated;
        TX_FRAME_START_O |-> TX_FRAME_READY_I && !PAUSE_SEND_O ##1 !PAUSE_SEND_O;
    endproperty
    a_start_gated: assert property (p_start_gated) else $error("frame start without ready or with pause");
    property p_one_start;
        TX_FRAME_START_O |=> !TX_FRAME_START_O;
    endproperty
    a_one_start: assert property (p_one_start) else $error("frame start twice in a row");
    property p_hold;
        RX_PAUSE_VALID_I && RX_PAUSE_DECODE_EN_O && CE_I && RX_PAUSE_QUANTA_I != 16'h0 |=> !TX_FRAME_START_O [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("frame start during pause hold");
    property p_halfdup;
        !FULL_DUPLEX_I && $past(!FULL_DUPLEX_I) |-> !RX_PAUSE_DECODE_EN_O;
    endproperty
    a_halfdup: assert property (p_halfdup) else $error("pause decode on in half duplex");
    property p_send_held;
        PAUSE_SEND_O && !PAUSE_SENT_I && CE_I |=> PAUSE_SEND_O;
    endproperty
    a_send_held: assert property (p_send_held) else $error("pause request dropped early");
    property p_send_drop;
        PAUSE_SEND_O && PAUSE_SENT_I && CE_I |=> !PAUSE_SEND_O;
    endproperty
    a_send_drop: assert property (p_send_drop) else $error("pause request kept after sent");
    property p_send_fd;
        $rose(PAUSE_SEND_O) |-> $past(FULL_DUPLEX_I);
    endproperty
    a_send_fd: assert property (p_send_fd) else $error("pause request in half duplex");
    property p_time_stable;
        PAUSE_SEND_O && !PAUSE_SENT_I |=> $stable(PAUSE_SEND_TIME_O);
    endproperty
    a_time_stable: assert property (p_time_stable) else $error("pause time moved during request");
endmodule

bind mtf_top mtf_top_props u_props
(
    .CLK_I                (CLK_I),
    .RESET_I              (RESET_I),
    .CE_I                 (CE_I),
    .FULL_DUPLEX_I        (FULL_DUPLEX_I),
    .TX_FRAME_READY_I     (TX_FRAME_READY_I),
    .TX_FRAME_START_O     (TX_FRAME_START_O),
    .PAUSE_SEND_O         (PAUSE_SEND_O),
    .PAUSE_SEND_TIME_O    (PAUSE_SEND_TIME_O),
    .PAUSE_SENT_I         (PAUSE_SENT_I),
    .RX_PAUSE_VALID_I     (RX_PAUSE_VALID_I),
    .RX_PAUSE_QUANTA_I    (RX_PAUSE_QUANTA_I),
    .RX_PAUSE_DECODE_EN_O (RX_PAUSE_DECODE_EN_O)
);

// *** sim/mtf_link_model.sv ***
// far-side model: transmit data path and pause frame generator with a settable delay
`timescale 1ns/1ns
module mtf_link_model
(
    input  wire        CLK_I,
    input  wire        RESET_I,
    input  wire [3:0]  delay_i,
    input  wire        start_i,
    input  wire        send_i,
    input  wire [15:0] send_time_i,
    output reg         done_o,
    output reg         sent_o,
    output reg  [15:0] last_time_o,
    output reg  [31:0] starts_o,
    output reg  [31:0] dones_o,
    output reg  [31:0] pauses_o
);
    reg [3:0] tx_cnt_ff;
    reg [3:0] ps_cnt_ff;

    // both jobs last delay_i cycles; a long delay stands in for a slow link
    always @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            done_o <= 1'b0;
            sent_o <= 1'b0;
            last_time_o <= 16'h0;
            starts_o <= 32'h0;
            dones_o <= 32'h0;
            pauses_o <= 32'h0;
            tx_cnt_ff <= 4'h0;
            ps_cnt_ff <= 4'h0;
        end
        else
        begin
            done_o <= 1'b0;
            sent_o <= 1'b0;
            if (start_i)
            begin
                starts_o <= starts_o + 1;
                tx_cnt_ff <= delay_i;
            end
            else if (tx_cnt_ff != 4'h0)
            begin
                tx_cnt_ff <= tx_cnt_ff - 1;
                done_o <= (tx_cnt_ff == 4'h1);
                dones_o <= dones_o + (tx_cnt_ff == 4'h1);
            end
            // the time field is latched at the start, as a real generator would
            if (send_i && !sent_o && ps_cnt_ff == 4'h0)
            begin
                ps_cnt_ff <= delay_i;
                last_time_o <= send_time_i;
            end
            else if (ps_cnt_ff != 4'h0)
            begin
                ps_cnt_ff <= ps_cnt_ff - 1;
                sent_o <= (ps_cnt_ff == 4'h1);
                pauses_o <= pauses_o + (ps_cnt_ff == 4'h1);
            end
        end
    end
endmodule

// *** sim/test_transmit_control_flow_control.sv ***
// self-checking bench for the transmit flow-control block
`timescale 1ns/1ns
`include "mtf_consts.vh"
module test_transmit_control_flow_control;
    reg         CLK_I = 1'b0;
    reg         RESET_I = 1'b1;
    reg         HSEL_I = 1'b0, HWRITE_I = 1'b0, FULL_DUPLEX_I = 1'b1, TX_FRAME_READY_I = 1'b0;
    reg         RX_PAUSE_VALID_I = 1'b0, BACKOFF_STEP_I = 1'b0;
    reg  [11:0] HADDR_I = 12'h0;
    reg  [1:0]  HTRANS_I = 2'b00;
    reg  [31:0] HWDATA_I = 32'h0;
    reg  [15:0] RX_FIFO_FILL_LEVEL_I = 16'h0, RX_PAUSE_QUANTA_I = 16'h0;
    reg  [7:0]  WATERMARK_ON_I = 8'h0, WATERMARK_OFF_I = 8'h0;
    reg  [3:0]  dly = 4'h6;
    wire [31:0] HRDATA_O, starts, dones, pauses;
    wire [15:0] PAUSE_SEND_TIME_O, BACKOFF_RANDOM_O, last_time;
    wire        HREADYOUT_O, HRESP_O, IRQ_O, TX_FRAME_START_O, TX_CORRUPT_FCS_O, PAUSE_SEND_O;
    wire        PAUSE_SENT_I, TX_FRAME_DONE_I, RX_PAUSE_DECODE_EN_O, RX_PAUSE_FORWARD_O;
    reg  [31:0] rdata;
    integer     mismatches = 0, check_count = 0, s0;

    always #25 CLK_I = ~CLK_I;

    mtf_top u_dut (.CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(1'b1), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
        .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(3'b010), .HWDATA_I(HWDATA_I),
        .HREADY_I(HREADYOUT_O), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
        .IRQ_O(IRQ_O), .FULL_DUPLEX_I(FULL_DUPLEX_I), .RX_FIFO_FILL_LEVEL_I(RX_FIFO_FILL_LEVEL_I),
        .WATERMARK_ON_I(WATERMARK_ON_I), .WATERMARK_OFF_I(WATERMARK_OFF_I),
        .TX_FRAME_READY_I(TX_FRAME_READY_I), .TX_FRAME_DONE_I(TX_FRAME_DONE_I),
        .TX_FRAME_START_O(TX_FRAME_START_O), .TX_CORRUPT_FCS_O(TX_CORRUPT_FCS_O),
        .PAUSE_SEND_O(PAUSE_SEND_O), .PAUSE_SEND_TIME_O(PAUSE_SEND_TIME_O), .PAUSE_SENT_I(PAUSE_SENT_I),
        .RX_PAUSE_VALID_I(RX_PAUSE_VALID_I), .RX_PAUSE_QUANTA_I(RX_PAUSE_QUANTA_I),
        .RX_PAUSE_DECODE_EN_O(RX_PAUSE_DECODE_EN_O), .RX_PAUSE_FORWARD_O(RX_PAUSE_FORWARD_O),
        .BACKOFF_STEP_I(BACKOFF_STEP_I), .BACKOFF_RANDOM_O(BACKOFF_RANDOM_O));

    mtf_link_model u_link (.CLK_I(CLK_I), .RESET_I(RESET_I), .delay_i(dly), .start_i(TX_FRAME_START_O),
        .send_i(PAUSE_SEND_O), .send_time_i(PAUSE_SEND_TIME_O), .done_o(TX_FRAME_DONE_I),
        .sent_o(PAUSE_SENT_I), .last_time_o(last_time), .starts_o(starts), .dones_o(dones),
        .pauses_o(pauses));

    task print_verdict;
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input [31:0] seen, input [31:0] exp, input string what);
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge CLK_I);
    endtask

    // one single ahb-lite transfer; the master holds each phase until hready is seen
    task bus(input reg wr, input reg [11:0] a, input reg [31:0] d);
        @(posedge CLK_I);
        HSEL_I   <= 1'b1;
        HTRANS_I <= 2'b10;
        HADDR_I  <= a;
        HWRITE_I <= wr;
        @(posedge CLK_I);
        while (HREADYOUT_O !== 1'b1) @(posedge CLK_I);
        HSEL_I   <= 1'b0;
        HTRANS_I <= 2'b00;
        HWDATA_I <= d;
        @(posedge CLK_I);
        while (HREADYOUT_O !== 1'b1) @(posedge CLK_I);
        rdata = HRDATA_O;
    endtask

    // the extra edge lets the written register land before outputs are looked at
    task wr(input [11:0] a, input [31:0] d);
        bus(1'b1, a, d);
        @(posedge CLK_I);
    endtask

    task rd(input [11:0] a, input [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        chk(rdata, exp, what);
    endtask

    task wait_pause(input [15:0] t);
        integer p0;
        p0 = pauses;
        repeat (100) if (pauses == p0) @(posedge CLK_I);
        chk(pauses, p0 + 1, "pause count");
        chk({16'h0, last_time}, {16'h0, t}, "pause time");
    endtask

    task rx_pause(input [15:0] q);
        @(posedge CLK_I);
        RX_PAUSE_VALID_I  <= 1'b1;
        RX_PAUSE_QUANTA_I <= q;
        @(posedge CLK_I);
        RX_PAUSE_VALID_I  <= 1'b0;
        cyc(1);
        s0 = starts;
    endtask

    task t_reset;
        rd(12'h108, 32'h0, "tx control");
        rd(12'h10C, 32'h0, "flow control");
        rd(12'h110, {16'h0, `MTF_SEED_RESET}, "seed");
        chk({16'h0, BACKOFF_RANDOM_O}, {16'h0, `MTF_SEED_RESET}, "lfsr");
        rd(12'h200, 32'h0, "unmapped");
        chk(32'(HRESP_O), 32'h0, "hresp okay");
    endtask

    task t_tx;
        TX_FRAME_READY_I <= 1'b1;
        wr(12'h11C, 32'h1);
        cyc(10);
        chk(starts, 32'h0, "starts while off");
        wr(12'h108, 32'h5); // transmitter on, corrupt fcs driven for every frame
        cyc(20);
        chk(32'(TX_CORRUPT_FCS_O), 32'h1, "corrupt fcs");
        wr(12'h108, 32'h4);
        rdata = 32'h0;
        repeat (20) if (rdata[1] !== 1'b1) bus(1'b0, 12'h108, 32'h0);
        chk(rdata, 32'h6, "disabled flag");
        chk(dones, starts, "frame finished");
        s0 = starts;
        cyc(20);
        chk(starts, s0, "starts after off");
        chk(32'(IRQ_O), 32'h1, "irq");
        rd(12'h118, 32'h1, "status");
        chk(32'(IRQ_O), 32'h0, "irq cleared");
        wr(12'h108, 32'h2);
        rd(12'h108, 32'h0, "flag cleared");
    endtask

    task t_manual;
        TX_FRAME_READY_I <= 1'b0;
        wr(12'h108, 32'h1);
        wr(12'h10C, 32'h8000_1234);
        wait_pause(16'h1234);
        rd(12'h10C, 32'h0000_1234, "force clear");
        FULL_DUPLEX_I <= 1'b0;
        s0 = pauses;
        wr(12'h10C, 32'h8000_0042);
        cyc(30);
        chk(pauses, s0, "half duplex pause");
        FULL_DUPLEX_I <= 1'b1;
        wait_pause(16'h0042);
    endtask

    task t_auto;
        WATERMARK_ON_I  <= 8'h04; // marks go in before the enable
        WATERMARK_OFF_I <= 8'h01;
        wr(12'h10C, 32'h4000_0055);
        RX_FIFO_FILL_LEVEL_I <= 16'h0800;
        wait_pause(16'h0055);
        RX_FIFO_FILL_LEVEL_I <= 16'h0400;
        s0 = pauses;
        cyc(30);
        chk(pauses, s0, "pause between marks");
        RX_FIFO_FILL_LEVEL_I <= 16'h0200;
        wait_pause(16'h0000);
        wr(12'h10C, 32'h0);
    endtask

    task t_honour;
        dly <= 4'h2;
        TX_FRAME_READY_I <= 1'b1;
        wr(12'h10C, 32'h2000_0000);
        chk(32'(RX_PAUSE_DECODE_EN_O), 32'h1, "decode on");
        rx_pause(16'h0003);
        cyc(3 * `MTF_SLOT_CYCLES - 8);
        chk(starts, s0, "starts in hold");
        cyc(12);
        chk(32'(starts > s0), 32'h1, "starts after hold");
        rx_pause(16'h0009);
        cyc(10);
        rx_pause(16'h0000);
        cyc(6);
        chk(32'(starts > s0), 32'h1, "zero quanta");
        wr(12'h10C, 32'h0);
        chk(32'(RX_PAUSE_DECODE_EN_O), 32'h0, "decode off");
        rx_pause(16'h00FF);
        cyc(6);
        chk(32'(starts > s0), 32'h1, "pause ignored");
        wr(12'h10C, 32'h1000_0000);
        chk(32'(RX_PAUSE_FORWARD_O), 32'h1, "forward");
        wr(12'h10C, 32'h0);
        chk(32'(RX_PAUSE_FORWARD_O), 32'h0, "sink");
        TX_FRAME_READY_I <= 1'b0;
    endtask

    task t_seed;
        wr(12'h110, 32'h0000_1357);
        cyc(2);
        chk({16'h0, BACKOFF_RANDOM_O}, 32'h0000_1357, "lfsr load");
        rd(12'h110, 32'h0000_1357, "seed");
        BACKOFF_STEP_I <= 1'b1;
        cyc(1);
        BACKOFF_STEP_I <= 1'b0;
        cyc(1);
        chk(32'(BACKOFF_RANDOM_O != 16'h1357), 32'h1, "lfsr step");
    endtask

    initial
    begin
        repeat (8) @(posedge CLK_I);
        RESET_I <= 1'b0;
        t_reset;
        t_tx;
        t_manual;
        t_auto;
        t_honour;
        t_seed;
        print_verdict;
    end

    // the whole sequence needs about five hundred cycles
    initial
    begin
        repeat (20000) @(posedge CLK_I);
        mismatches = mismatches + 1;
        print_verdict;
    end
endmodule
